// [src/teio_pkg.sv]
package teio_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] CONFIG_OFFSET  = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;
    localparam logic [7:0] RESULT_OFFSET  = 8'h0C;

    // ------------------------------------------------------------
    // control register fields (write-one pulses, self clearing)
    // ------------------------------------------------------------
    localparam int CTRL_PANEL_START_BIT  = 0;
    localparam int CTRL_PANEL_STOP_BIT   = 1;
    localparam int CTRL_PASS_BIT         = 2;
    localparam int CTRL_UPPER_FAIL_BIT   = 3;
    localparam int CTRL_LOWER_FAIL_BIT   = 4;
    localparam int CTRL_RELEASE_BIT      = 5;
    localparam int CTRL_ENTER_SETUP_BIT  = 6;
    localparam int CTRL_LEAVE_SETUP_BIT  = 7;

    // ------------------------------------------------------------
    // config register fields
    // ------------------------------------------------------------
    localparam int CFG_INTERLOCK_BIT     = 0;
    localparam int CFG_INSUL_MODE_BIT    = 1;
    localparam int CFG_REMOTE_BOX_BIT    = 2;
    localparam int CFG_HV_PRESENT_BIT    = 3;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // status register field positions
    // ------------------------------------------------------------
    localparam int ST_STATE_LSB          = 0;
    localparam int ST_IN_LSB             = 8;
    localparam int ST_OUT_LSB            = 16;

    // ------------------------------------------------------------
    // input synchroniser depth and status output width
    // ------------------------------------------------------------
    localparam int SYNC_STAGES           = 3;
    localparam int NUM_INPUTS            = 4;
    localparam int NUM_OUTPUTS           = 10;

    // ------------------------------------------------------------
    // instrument states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_READY   = 6'h01,
        ST_TEST    = 6'h02,
        ST_PASS    = 6'h04,
        ST_FAIL    = 6'h08,
        ST_SETUP   = 6'h10,
        ST_LOCKED  = 6'h20
    } teio_state_e;

endpackage : teio_pkg

// [src/teio_ctrl.sv]
`timescale 1ns/1ps
// Functional notes
// - ready output low exactly while in the ready state; held high through reset until the first edge after release.
// - lower-fail output low while failed below lower limit.
// - upper-fail output low while failed above upper limit.
// - pass output low while in the pass state.
// - test output low for the whole test state.
// - high-voltage output low whenever output voltage is present.
// - external start only accepted while external enable is low.
// - stop and interlock honoured regardless of external enable.
// - external enable changing during a test aborts the test.
// - external start low acts exactly like the panel start key.
// - external stop low acts exactly like the panel stop key.
// - interlock set and input open disables all key operations.
// - interlock input low cancels the interlock, back to ready.
// - interlock behaviour only when the interlock option is set.
// - withstand-mode output low while a withstand test runs.
// - insulation-mode output low while an insulation test runs.
// - withstand-fail output low in a withstand fail state.
// - insulation-fail output low in an insulation fail state.
// - start, stop and enable inputs are active low; the interlock engages while its input is high (open).
// - start only from ready; test entry raises ready, lowers test.
// - start priority remote box, then external, then panel.
// - setup-like states drive every status output except hv-on high.
module teio_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        remote_start,
    input  wire logic        start_n,
    input  wire logic        stop_n,
    input  wire logic        external_inputs_enable_n,
    input  wire logic        interlock_n,
    output logic             ready_n,
    output logic             lower_fail_n,
    output logic             upper_fail_n,
    output logic             pass_n,
    output logic             test_n,
    output logic             hv_on_n,
    output logic             withstand_mode_n,
    output logic             insulation_mode_n,
    output logic             withstand_fail_n,
    output logic             insulation_fail_n
);
    import teio_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    teio_state_e                  state;
    teio_state_e                  next_state;
    logic [NUM_INPUTS-1:0]        pin_raw;
    logic [NUM_INPUTS-1:0]        pin_lvl;
    logic [NUM_INPUTS-1:0]        pin_prev;
    logic [31:0]                  config_reg;
    logic                         upper_hit;
    logic                         lower_hit;
    logic                         insul_test;
    logic                         next_insul;
    logic [NUM_OUTPUTS-1:0]       next_out_n;
    logic [NUM_OUTPUTS-1:0]       out_n;
    logic                         wr_ctrl;
    logic                         ext_en;
    logic                         ext_start_fall;
    logic                         ext_stop_fall;
    logic                         ext_en_change;
    logic                         lock_active;
    logic                         start_req;
    logic                         stop_req;
    logic                         remote_sel;
    logic                         apb_access;

    // input order: 0 start, 1 stop, 2 enable, 3 interlock
    assign pin_raw = {interlock_n, external_inputs_enable_n, stop_n, start_n};

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // stage 1 is read only by stage 2; a change counts once 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_sync
            logic [SYNC_STAGES-1:0] sh;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sh <= '1;                               // inputs idle open (high)
                end else begin
                    sh <= {sh[SYNC_STAGES-2:0], pin_raw[gi]};
                end
            end
            // agreed level held until stages two and three match again
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_lvl[gi]  <= 1'b1;
                    pin_prev[gi] <= 1'b1;
                end else begin
                    if (sh[1] == sh[2]) begin
                        pin_lvl[gi] <= sh[2];
                    end
                    pin_prev[gi] <= pin_lvl[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign apb_access     = psel && penable;
    assign wr_ctrl        = apb_access && pwrite && (paddr == CTRL_OFFSET);
    assign ext_en         = !pin_lvl[2];
    assign ext_start_fall = pin_prev[0] && !pin_lvl[0];
    assign ext_stop_fall  = pin_prev[1] && !pin_lvl[1];
    assign ext_en_change  = pin_prev[2] != pin_lvl[2];
    assign remote_sel     = config_reg[CFG_REMOTE_BOX_BIT];
    assign lock_active    = config_reg[CFG_INTERLOCK_BIT] && pin_lvl[3];

    // higher-priority start source masks lower ones
    always_comb begin
        if (remote_sel) begin
            start_req = remote_start;
        end else if (ext_en) begin
            start_req = ext_start_fall;
        end else begin
            start_req = wr_ctrl && pwdata[CTRL_PANEL_START_BIT];
        end
    end

    // stop never gated by the enable input
    assign stop_req = ext_stop_fall
                   || (wr_ctrl && pwdata[CTRL_PANEL_STOP_BIT]);

    // ------------------------------------------------------------
    // instrument state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_READY: begin
                if (wr_ctrl && pwdata[CTRL_ENTER_SETUP_BIT]) begin
                    next_state = ST_SETUP;
                end else if (start_req) begin
                    next_state = ST_TEST;
                end
            end
            ST_TEST: begin
                if (stop_req || ext_en_change) begin
                    next_state = ST_READY;
                end else if (wr_ctrl && (pwdata[CTRL_UPPER_FAIL_BIT]
                                      || pwdata[CTRL_LOWER_FAIL_BIT])) begin
                    next_state = ST_FAIL;
                end else if (wr_ctrl && pwdata[CTRL_PASS_BIT]) begin
                    next_state = ST_PASS;
                end
            end
            ST_PASS, ST_FAIL: begin
                if (stop_req || (wr_ctrl && pwdata[CTRL_RELEASE_BIT])) begin
                    next_state = ST_READY;
                end
            end
            ST_SETUP: begin
                if (stop_req || (wr_ctrl && pwdata[CTRL_LEAVE_SETUP_BIT])) begin
                    next_state = ST_READY;
                end
            end
            ST_LOCKED: begin
                if (!lock_active) begin
                    next_state = ST_READY;
                end
            end
            default: begin
                next_state = ST_READY;
            end
        endcase
        // interlock overrides everything; keys ignored while locked
        if (lock_active) begin
            next_state = ST_LOCKED;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_READY;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // test mode and result latches
    // ------------------------------------------------------------
    // mode sampled at start so a config write mid-test cannot flip it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insul_test <= 1'b0;
            upper_hit  <= 1'b0;
            lower_hit  <= 1'b0;
        end else begin
            if (state == ST_READY && next_state == ST_TEST) begin
                insul_test <= config_reg[CFG_INSUL_MODE_BIT];
                upper_hit  <= 1'b0;
                lower_hit  <= 1'b0;
            end else if (state == ST_TEST && next_state == ST_FAIL) begin
                upper_hit  <= pwdata[CTRL_UPPER_FAIL_BIT];
                lower_hit  <= pwdata[CTRL_LOWER_FAIL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs, all active low, registered
    // ------------------------------------------------------------
    // mode the outputs show, already right in the first test cycle;
    // the latch alone would lag one edge and flash the previous mode
    assign next_insul = (state == ST_READY && next_state == ST_TEST)
                      ? config_reg[CFG_INSUL_MODE_BIT] : insul_test;

    always_comb begin
        next_out_n    = '1;
        next_out_n[0] = !(next_state == ST_READY);
        next_out_n[1] = !(next_state == ST_FAIL && lower_hit);
        next_out_n[2] = !(next_state == ST_FAIL && upper_hit);
        next_out_n[3] = !(next_state == ST_PASS);
        next_out_n[4] = !(next_state == ST_TEST);
        next_out_n[5] = !config_reg[CFG_HV_PRESENT_BIT];
        next_out_n[6] = !(next_state == ST_TEST && !next_insul);
        next_out_n[7] = !(next_state == ST_TEST && next_insul);
        next_out_n[8] = !(next_state == ST_FAIL && !insul_test);
        next_out_n[9] = !(next_state == ST_FAIL && insul_test);
    end

    // lower and upper fail bits use next-cycle latch values via the same write data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_n <= '1;
        end else begin
            out_n <= next_out_n;
            if (state == ST_TEST && next_state == ST_FAIL) begin
                out_n[1] <= !pwdata[CTRL_LOWER_FAIL_BIT];
                out_n[2] <= !pwdata[CTRL_UPPER_FAIL_BIT];
            end
        end
    end

    assign ready_n           = out_n[0];
    assign lower_fail_n      = out_n[1];
    assign upper_fail_n      = out_n[2];
    assign pass_n            = out_n[3];
    assign test_n            = out_n[4];
    assign hv_on_n           = out_n[5];
    assign withstand_mode_n  = out_n[6];
    assign insulation_mode_n = out_n[7];
    assign withstand_fail_n  = out_n[8];
    assign insulation_fail_n = out_n[9];

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // zero wait states keeps the master simple; unmapped gives slverr
    assign pready  = 1'b1;
    assign pslverr = apb_access && !(paddr == CTRL_OFFSET || paddr == CONFIG_OFFSET
                                  || paddr == STATUS_OFFSET || paddr == RESULT_OFFSET);

    // config register; interlock option cannot be set while pin is open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= CONFIG_RESET;
        end else if (apb_access && pwrite && paddr == CONFIG_OFFSET) begin
            config_reg <= {28'h0000000, pwdata[3:0]};
            if (pin_lvl[3] && !config_reg[CFG_INTERLOCK_BIT]) begin
                config_reg[CFG_INTERLOCK_BIT] <= 1'b0;
            end
        end
    end

    // read data registered during the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CONFIG_OFFSET: prdata <= config_reg;
                STATUS_OFFSET: begin
                    prdata <= 32'h0000_0000;
                    prdata[ST_STATE_LSB +: 6]          <= state;
                    prdata[ST_IN_LSB +: NUM_INPUTS]    <= pin_lvl;
                    prdata[ST_OUT_LSB +: NUM_OUTPUTS]  <= out_n;
                end
                RESULT_OFFSET: prdata <= {29'h00000000, insul_test, upper_hit, lower_hit};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // outputs stay high through reset and first follow the state one edge
    // after release, so the ready check tying its output to state waits for that edge
    logic run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b1;
        end
    end

    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        run_q |-> ready_n == (state != ST_READY)) else $error("ready out wrong");
    AST_TEST: assert property (@(posedge pclk) disable iff (!presetn)
        test_n == (state != ST_TEST)) else $error("test out wrong");
    AST_PASS: assert property (@(posedge pclk) disable iff (!presetn)
        pass_n == (state != ST_PASS)) else $error("pass out wrong");
    AST_START_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_READY && !remote_sel && !ext_en && ext_start_fall && !wr_ctrl
         && !lock_active) |=> state == ST_READY) else $error("start not gated");
    AST_ENABLE_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_TEST && ext_en_change && !lock_active) |=> !ready_n && test_n)
        else $error("enable change did not abort");
    AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_TEST && ext_stop_fall && !lock_active) |=> state == ST_READY)
        else $error("stop ignored");
    AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        lock_active |=> state == ST_LOCKED && ready_n) else $error("interlock ignored");
    AST_SETUP_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_SETUP) |-> out_n[4:0] == 5'h1F) else $error("setup drives status");
    AST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        !withstand_mode_n |-> !test_n && !insul_test) else $error("mode out wrong");
    AST_FAIL_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        !insulation_fail_n |-> state == ST_FAIL && insul_test) else $error("fail mode wrong");
    AST_LOWER: assert property (@(posedge pclk) disable iff (!presetn)
        !lower_fail_n |-> state == ST_FAIL && lower_hit) else $error("lower fail wrong");
    AST_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        !upper_fail_n |-> state == ST_FAIL && upper_hit) else $error("upper fail wrong");
    // hv output lags its config bit by the output register
    AST_HV: assert property (@(posedge pclk) disable iff (!presetn)
        run_q |-> hv_on_n == !$past(config_reg[CFG_HV_PRESENT_BIT]))
        else $error("hv out wrong");
    AST_IMODE: assert property (@(posedge pclk) disable iff (!presetn)
        !insulation_mode_n |-> !test_n && insul_test) else $error("imode out wrong");
    AST_WFAIL: assert property (@(posedge pclk) disable iff (!presetn)
        !withstand_fail_n |-> state == ST_FAIL && !insul_test) else $error("wfail wrong");
    AST_START: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_READY && next_state == ST_TEST) |=> ready_n && !test_n)
        else $error("start outputs wrong");
    AST_UNLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_LOCKED && !lock_active) |=> state == ST_READY)
        else $error("interlock not cancelled");

    COV_START_EXT: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_READY && ext_en && ext_start_fall ##1 state == ST_TEST);
    COV_PASS: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_TEST ##1 state == ST_PASS);
    COV_FAIL: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_TEST ##1 state == ST_FAIL);
    COV_LOCK: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_LOCKED ##1 state == ST_READY);
    COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_TEST && ext_en_change ##1 state == ST_READY);

endmodule : teio_ctrl

// [bench/teio_panel_model.sv]
`timescale 1ns/1ps
module teio_panel_model (
    input  wire logic pclk,
    output logic      start_n,
    output logic      stop_n,
    output logic      external_inputs_enable_n,
    output logic      interlock_n
);
    // ------------------------------------------------------------
    // switch panel outside the tester
    // ------------------------------------------------------------
    // open contacts read high through the pull-up, closed ones low
    initial begin
        {interlock_n, external_inputs_enable_n, stop_n, start_n} = 4'hF;
    end

    // one clean change per call, no bounce: contacts are debounced here
    task automatic set_pins(input logic [3:0] lv);
        @(posedge pclk);
        {interlock_n, external_inputs_enable_n, stop_n, start_n} <= lv;
    endtask : set_pins
endmodule : teio_panel_model

// [bench/tb_tester_external_io_control.sv]
`timescale 1ns/1ps
module tb_tester_external_io_control;
    import teio_pkg::*;
    // ------------------------------------------------------------
    // stimulus, instances and table
    // ------------------------------------------------------------
    localparam logic [1:0] K_CTL = 2'h0, K_CFG = 2'h1, K_PIN = 2'h2, K_REM = 2'h3;
    localparam logic [9:0] M_ALL = 10'h3FF, M_NOM = 10'h3F3; // modes unspecified after test
    localparam int SETTLE = 8; // sync plus state plus output register
    localparam int NROWS = 42;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] d;
        logic [9:0] ex;
        logic [9:0] mk;
    } teio_row_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        remote_start = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        start_n, stop_n, external_inputs_enable_n, interlock_n;
    logic        ready_n, lower_fail_n, upper_fail_n, pass_n, test_n, hv_on_n;
    logic        withstand_mode_n, insulation_mode_n, withstand_fail_n, insulation_fail_n;
    logic [9:0]  outs;
    logic [31:0] rd;
    logic        er;
    int          num_errors = 0;
    int          comparisons = 0;
    assign outs = {ready_n, lower_fail_n, upper_fail_n, pass_n, test_n, hv_on_n,
                   withstand_mode_n, insulation_mode_n, withstand_fail_n, insulation_fail_n};
    // pin codes are {interlock, enable, stop, start}, 1 = open
    teio_row_s rows [NROWS] = '{
        '{K_CTL, 8'h01, 10'h3D7, M_ALL}, '{K_CTL, 8'h04, 10'h3BF, M_NOM},
        '{K_CTL, 8'h20, 10'h1FF, M_ALL}, '{K_CFG, 8'h02, 10'h1FF, M_ALL},
        '{K_CTL, 8'h01, 10'h3DB, M_ALL}, '{K_CTL, 8'h08, 10'h37E, M_NOM},
        '{K_CTL, 8'h20, 10'h1FF, M_ALL}, '{K_CFG, 8'h00, 10'h1FF, M_ALL},
        '{K_CTL, 8'h01, 10'h3D7, M_ALL}, '{K_CTL, 8'h10, 10'h2FD, M_NOM},
        '{K_CTL, 8'h20, 10'h1FF, M_ALL}, '{K_CTL, 8'h01, 10'h3D7, M_ALL},
        '{K_CTL, 8'h18, 10'h27D, M_NOM}, '{K_CTL, 8'h02, 10'h1FF, M_ALL},
        '{K_CTL, 8'h40, 10'h3FF, M_ALL}, '{K_CTL, 8'h80, 10'h1FF, M_ALL},
        '{K_CFG, 8'h08, 10'h1EF, M_ALL}, '{K_CFG, 8'h00, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0B, 10'h1FF, M_ALL}, '{K_PIN, 8'h0A, 10'h3D7, M_ALL},
        '{K_PIN, 8'h0B, 10'h3D7, M_ALL}, '{K_PIN, 8'h09, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0B, 10'h1FF, M_ALL}, '{K_PIN, 8'h0A, 10'h3D7, M_ALL},
        '{K_PIN, 8'h0B, 10'h3D7, M_ALL}, '{K_PIN, 8'h0F, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0E, 10'h1FF, M_ALL}, '{K_PIN, 8'h0F, 10'h1FF, M_ALL},
        '{K_CTL, 8'h01, 10'h3D7, M_ALL}, '{K_PIN, 8'h0D, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0F, 10'h1FF, M_ALL}, '{K_PIN, 8'h0B, 10'h1FF, M_ALL},
        '{K_CTL, 8'h01, 10'h1FF, M_ALL}, '{K_PIN, 8'h0F, 10'h1FF, M_ALL},
        '{K_CFG, 8'h04, 10'h1FF, M_ALL}, '{K_PIN, 8'h0B, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0A, 10'h1FF, M_ALL}, '{K_PIN, 8'h0B, 10'h1FF, M_ALL},
        '{K_REM, 8'h00, 10'h3D7, M_ALL}, '{K_PIN, 8'h09, 10'h1FF, M_ALL},
        '{K_PIN, 8'h0F, 10'h1FF, M_ALL}, '{K_CFG, 8'h00, 10'h1FF, M_ALL}
    };

    teio_ctrl u_teio_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .remote_start(remote_start),
        .start_n(start_n), .stop_n(stop_n),
        .external_inputs_enable_n(external_inputs_enable_n), .interlock_n(interlock_n),
        .ready_n(ready_n), .lower_fail_n(lower_fail_n), .upper_fail_n(upper_fail_n),
        .pass_n(pass_n), .test_n(test_n), .hv_on_n(hv_on_n),
        .withstand_mode_n(withstand_mode_n), .insulation_mode_n(insulation_mode_n),
        .withstand_fail_n(withstand_fail_n), .insulation_fail_n(insulation_fail_n));
    teio_panel_model u_teio_panel_model (.pclk(pclk), .start_n(start_n), .stop_n(stop_n),
        .external_inputs_enable_n(external_inputs_enable_n), .interlock_n(interlock_n));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // ------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------
    // request held until pready is seen high; no wait count assumed
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic check_out(input logic [9:0] ex, input logic [9:0] mk);
        comparisons++;
        if ((outs & mk) !== (ex & mk)) begin
            num_errors++;
            $display("[FAIL] status_outputs expected %h seen %h", ex & mk, outs & mk);
        end
    endtask : check_out

    task automatic check_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : check_word

    task automatic step(input logic [1:0] op, input logic [7:0] d, input logic [9:0] ex);
        case (op)
            K_CTL: apb_xfer(1'b1, CTRL_OFFSET, {24'h000000, d});
            K_CFG: apb_xfer(1'b1, CONFIG_OFFSET, {24'h000000, d});
            K_PIN: u_teio_panel_model.set_pins(d[3:0]);
            default: begin
                @(posedge pclk);
                remote_start <= 1'b1;
                @(posedge pclk);
                remote_start <= 1'b0;
            end
        endcase
        repeat (SETTLE) @(posedge pclk);
        check_out(ex, M_ALL);
    endtask : step

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        check_out(10'h3FF, M_ALL);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check_out(10'h1FF, M_ALL);
        apb_xfer(1'b0, CONFIG_OFFSET, 32'h0000_0000);
        check_word("config_reset", CONFIG_RESET, rd);
        apb_xfer(1'b0, STATUS_OFFSET, 32'h0000_0000);
        check_word("state_ready", 32'h0000_0001, {26'h0, rd[5:0]});
        apb_xfer(1'b0, 8'h10, 32'h0000_0000);
        check_word("unmapped_err", 32'h0000_0001, {31'h0, er});
        check_word("unmapped_data", 32'h0000_0000, rd);
        check_word("pready", 32'h0000_0001, {31'h0, pready});
        for (int i = 0; i < NROWS; i++) begin
            step(rows[i].op, rows[i].d, rows[i].ex);
            check_out(rows[i].ex, rows[i].mk);
        end
        // option cannot be armed while the interlock pin is open
        apb_xfer(1'b1, CONFIG_OFFSET, 32'h0000_0001);
        apb_xfer(1'b0, CONFIG_OFFSET, 32'h0000_0000);
        check_word("interlock_refused", 32'h0000_0000, rd);
        step(K_PIN, 8'h07, 10'h1FF);
        step(K_CFG, 8'h01, 10'h1FF);
        step(K_PIN, 8'h0F, 10'h3FF);
        step(K_CTL, 8'h01, 10'h3FF);
        step(K_PIN, 8'h07, 10'h1FF);
        step(K_CFG, 8'h00, 10'h1FF);
        step(K_PIN, 8'h0F, 10'h1FF);
        step(K_CTL, 8'h01, 10'h3D7);
        // second reset in the middle of a running test
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check_out(10'h3FF, M_ALL);
        presetn <= 1'b1;
        repeat (SETTLE) @(posedge pclk);
        check_out(10'h1FF, M_ALL);
        conclude();
    end

    // watchdog well past the expected few hundred cycles
    initial begin
        repeat (6000) @(posedge pclk);
        num_errors++;
        conclude();
    end
endmodule : tb_tester_external_io_control
